// ### bram_consts.svh
// Purpose: Register indices, field positions and reset values of the
//          two-channel buffer RAM controller.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef BRAM_CONSTS_SVH
`define BRAM_CONSTS_SVH

`define BRAM_IDX_W 7
`define BRAM_IDX_C0_BASE 7'h00
`define BRAM_IDX_C1_BASE 7'h04
`define BRAM_OFS_ADDR_LO 7'h00
`define BRAM_OFS_ADDR_HI 7'h01
`define BRAM_OFS_CNT_LO 7'h02
`define BRAM_OFS_CNT_HI 7'h03
`define BRAM_IDX_C0_CTRL 7'h08
`define BRAM_IDX_C1_CTRL 7'h09
`define BRAM_IDX_STATUS 7'h00
`define BRAM_IDX_MICRO 7'h18
`define BRAM_ST_EN_LSB 2
`define BRAM_CTRL_RST 8'h00
`define BRAM_ADDR_RST 16'h0000
`define BRAM_CNT_RST 16'h0000
`define BRAM_HSIZE_WORD 3'h2

`endif

// ### bram_pkg.sv
// Purpose: Types shared by the buffer RAM controller modules.
// Assumes: Nothing.
// Notes:   Control byte layout, bit 7 down to bit 0.
package bram_pkg;

  typedef enum logic {
    BRAM_HS_CHAN,
    BRAM_HS_SCSI
  } bram_hs_t;

  typedef struct packed {
    bram_hs_t proto;
    logic [1:0] rsv;
    logic keep_en;
    logic irq_en;
    logic reload;
    logic dir;
    logic enable;
  } bram_ctrl_t;

endpackage

// ### bram_chan_if.sv
// Purpose: Link between the register front end and one channel.
// Assumes: Strobes are one-cycle pulses in the hclk domain.
// Notes:   host drives strobes, chan returns channel state.
`timescale 1ns/1ps
`default_nettype none
interface bram_chan_if;
  import bram_pkg::*;
  logic [7:0] wdata;
  logic wr_addr_lo;
  logic wr_addr_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_ctrl;
  logic step;
  bram_ctrl_t ctrl;
  logic [15:0] addr;
  logic [15:0] count;
  logic enabled;
  logic irq_evt;
  modport host(
    output wdata, wr_addr_lo, wr_addr_hi, wr_cnt_lo, wr_cnt_hi,
    output wr_ctrl, step,
    input ctrl, addr, count, enabled, irq_evt
  );
  modport chan(
    input wdata, wr_addr_lo, wr_addr_hi, wr_cnt_lo, wr_cnt_hi,
    input wr_ctrl, step,
    output ctrl, addr, count, enabled, irq_evt
  );
endinterface
`default_nettype wire

// ### bram_chan.sv
// Purpose: One channel: address up counter, transfer down counter,
//          control byte, enable and end-of-block event.
// Assumes: step is only raised while the channel is enabled.
// Notes:   A register write wins over a step in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "bram_consts.svh"
module bram_chan import bram_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Front end
  bram_chan_if.chan cif
);
  logic [15:0] saved;
  logic en_q;
  wire last = cif.count == 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cif.addr <= `BRAM_ADDR_RST;
    end else if (cif.wr_addr_lo) begin
      cif.addr[7:0] <= cif.wdata;
    end else if (cif.wr_addr_hi) begin
      cif.addr[15:8] <= cif.wdata;
    end else if (cif.step) begin
      cif.addr <= cif.addr + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cif.count <= `BRAM_CNT_RST;
      saved <= `BRAM_CNT_RST;
    end else if (cif.wr_cnt_lo) begin
      cif.count[7:0] <= cif.wdata;
      saved[7:0] <= cif.wdata;
    end else if (cif.wr_cnt_hi) begin
      cif.count[15:8] <= cif.wdata;
      saved[15:8] <= cif.wdata;
    end else if (cif.step) begin
      if (last && cif.ctrl.reload) begin
        cif.count <= saved;
      end else begin
        cif.count <= cif.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cif.ctrl <= `BRAM_CTRL_RST;
      cif.enabled <= 1'b0;
    end else if (cif.wr_ctrl) begin
      cif.ctrl <= cif.wdata;
      cif.enabled <= cif.wdata[0];
    end else if (cif.step && last && !cif.ctrl.keep_en) begin
      cif.enabled <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= cif.enabled;
    end
  end

  // The event rides on the falling enable, so a channel kept enabled
  // never reports the end of its block.
  assign cif.irq_evt = en_q & ~cif.enabled & cif.ctrl.irq_en;

  wire quiet = !cif.wr_addr_lo && !cif.wr_addr_hi;
  wire cquiet = !cif.wr_cnt_lo && !cif.wr_cnt_hi;

  a_addr_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cif.step && quiet |=> cif.addr == $past(cif.addr) + 16'h0001
  ) else $error("address did not step by one");

  a_addr_carry: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cif.step && quiet && cif.addr[7:0] != 8'hff
    |=> cif.addr[15:8] == $past(cif.addr[15:8])
  ) else $error("high address moved without carry");

  a_count_borrow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cif.step && cquiet && cif.count[7:0] == 8'h00 && !last
    |=> cif.count[15:8] == $past(cif.count[15:8]) - 8'h01
  ) else $error("high count missed the borrow");

  a_count_reload: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cif.step && cquiet && last && cif.ctrl.reload |=> cif.count == saved
  ) else $error("count not reloaded at block end");

  a_auto_disable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cif.step && !cif.wr_ctrl && last && !cif.ctrl.keep_en
    |=> !cif.enabled ##1 !cif.enabled || $past(cif.wr_ctrl)
  ) else $error("channel stayed enabled at count zero");

  a_stay_enabled: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cif.step && !cif.wr_ctrl && cif.ctrl.keep_en |=> cif.enabled
  ) else $error("kept channel was disabled");
endmodule
`default_nettype wire

// ### bram_dma.sv
// Purpose: Two-channel buffer RAM controller with an AHB-Lite register
//          slave, a sequencer byte port and a SCSI byte port.
// Assumes: Synchronous buffer RAM with one cycle of read latency.
// Notes:   Channel 0 has priority over channel 1 for each RAM cycle.
`timescale 1ns/1ps
`default_nettype none
`include "bram_consts.svh"
module bram_dma import bram_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Buffer RAM
  output logic ram_en,
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  // Data sequencer, channel 0
  input wire logic seq_req,
  input wire logic [7:0] seq_wdata,
  output logic seq_ack,
  output logic [7:0] seq_rdata,
  // SCSI interface, channel 1
  input wire logic chan1_request_in,
  input wire logic [7:0] scsi_wdata,
  output logic chan1_acknowledge_out,
  output logic [7:0] scsi_rdata,
  // Memory interrupt
  output logic int_mem
);
  bram_chan_if cif[2] ();

  logic [1:0] en;
  logic [1:0] dir;
  logic [1:0] irq_evt;
  logic [15:0] addr [2];
  logic [15:0] count [2];
  bram_hs_t proto1;

  // Bus front end.
  logic dp_valid;
  logic dp_write;
  logic [`BRAM_IDX_W-1:0] dp_idx;
  logic rd_done;
  logic micro_asked;
  logic micro_busy;
  logic [31:0] rd_mux;
  logic [1:0] cause;
  logic [1:0] next_cause;

  // Channel request and RAM pipeline.
  logic pend0;
  logic pend1;
  logic src0_micro;
  logic [7:0] wbyte0;
  logic [7:0] wbyte1;
  logic chan1_request_in_q;
  logic a_ch;
  logic a_micro;
  logic b_valid;
  logic b_ch;
  logic b_micro;
  logic b_rd;
  logic ack1p;

  wire take = hsel & htrans[1] & hready & (hsize == `BRAM_HSIZE_WORD);
  wire wr_en = dp_valid & dp_write;
  wire rd_phase = dp_valid & ~dp_write & ~rd_done;
  wire is_micro = dp_idx == `BRAM_IDX_MICRO;
  wire micro_rd_need = rd_phase & is_micro & en[0] & ~dir[0];
  wire ack_micro = b_valid & ~b_ch & b_micro;
  wire rd_finish = micro_busy ? ack_micro : ~micro_rd_need;
  wire micro_wr = wr_en & is_micro & en[0] & dir[0];
  wire micro_rd = micro_rd_need & ~micro_asked;
  wire micro_req = micro_wr | micro_rd;
  wire ch0_evt = (micro_req | seq_req) & en[0];
  wire ch1_evt = chan1_request_in & ~chan1_request_in_q & en[1];
  wire g0 = pend0 & en[0];
  wire g1 = pend1 & en[1] & ~g0;
  wire busy1 = (ram_en & a_ch) | (b_valid & b_ch);

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      localparam logic [`BRAM_IDX_W-1:0] BASE =
        (c == 0) ? `BRAM_IDX_C0_BASE : `BRAM_IDX_C1_BASE;
      localparam logic [`BRAM_IDX_W-1:0] CTRL =
        (c == 0) ? `BRAM_IDX_C0_CTRL : `BRAM_IDX_C1_CTRL;
      // Each channel decodes its own four bytes and control byte.
      assign cif[c].wdata = hwdata[7:0];
      assign cif[c].wr_addr_lo = wr_en & (dp_idx == BASE + `BRAM_OFS_ADDR_LO);
      assign cif[c].wr_addr_hi = wr_en & (dp_idx == BASE + `BRAM_OFS_ADDR_HI);
      assign cif[c].wr_cnt_lo = wr_en & (dp_idx == BASE + `BRAM_OFS_CNT_LO);
      assign cif[c].wr_cnt_hi = wr_en & (dp_idx == BASE + `BRAM_OFS_CNT_HI);
      assign cif[c].wr_ctrl = wr_en & (dp_idx == CTRL);
      assign cif[c].step = (c == 0) ? g0 : g1;
      assign en[c] = cif[c].enabled;
      assign dir[c] = cif[c].ctrl.dir;
      assign irq_evt[c] = cif[c].irq_evt;
      assign addr[c] = cif[c].addr;
      assign count[c] = cif[c].count;
      bram_chan u_chan (
        .hclk(hclk),
        .hresetn(hresetn),
        .cif(cif[c])
      );
    end
  endgenerate

  assign proto1 = cif[1].ctrl.proto;

  // Address phase capture; reads always take at least one wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx <= '0;
    end else if (hready) begin
      dp_valid <= take;
      dp_write <= hwrite;
      dp_idx <= haddr[`BRAM_IDX_W+1:2];
    end
  end

  assign hreadyout = ~dp_valid | dp_write | rd_done;
  assign hresp = 1'b0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dp_idx == `BRAM_IDX_STATUS) begin
      rd_mux[1:0] = cause;
      rd_mux[`BRAM_ST_EN_LSB+1:`BRAM_ST_EN_LSB] = en;
    end else if (dp_idx == `BRAM_IDX_C0_BASE + `BRAM_OFS_CNT_LO) begin
      rd_mux[7:0] = count[0][7:0];
    end else if (dp_idx == `BRAM_IDX_C0_BASE + `BRAM_OFS_CNT_HI) begin
      rd_mux[7:0] = count[0][15:8];
    end else if (dp_idx == `BRAM_IDX_C1_BASE + `BRAM_OFS_CNT_LO) begin
      rd_mux[7:0] = count[1][7:0];
    end else if (dp_idx == `BRAM_IDX_C1_BASE + `BRAM_OFS_CNT_HI) begin
      rd_mux[7:0] = count[1][15:8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (rd_done) begin
      rd_done <= 1'b0;
    end else if (rd_phase && rd_finish) begin
      rd_done <= 1'b1;
      hrdata <= micro_busy ? {24'h00_0000, ram_rdata} : rd_mux;
    end
  end

  // A processor port read waits for its RAM byte once it is granted.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      micro_asked <= 1'b0;
      micro_busy <= 1'b0;
    end else if (rd_phase && rd_finish) begin
      micro_asked <= 1'b0;
      micro_busy <= 1'b0;
    end else begin
      if (micro_rd && en[0]) begin
        micro_asked <= 1'b1;
      end
      if (g0 && src0_micro && !dp_write && dp_valid) begin
        micro_busy <= 1'b1;
      end
    end
  end

  // Status causes: an event in the clearing read cycle is kept.
  always_comb begin
    next_cause = cause;
    if (rd_phase && rd_finish && dp_idx == `BRAM_IDX_STATUS) begin
      next_cause = 2'b00;
    end
    next_cause = next_cause | irq_evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause <= 2'b00;
      int_mem <= 1'b0;
    end else begin
      cause <= next_cause;
      int_mem <= |next_cause;
    end
  end

  // Channel 0 requests from the sequencer or the processor ports.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend0 <= 1'b0;
      src0_micro <= 1'b0;
      wbyte0 <= 8'h00;
    end else if (!en[0]) begin
      pend0 <= 1'b0;
    end else if (ch0_evt) begin
      pend0 <= 1'b1;
      src0_micro <= micro_req;
      wbyte0 <= micro_req ? hwdata[7:0] : seq_wdata;
    end else if (g0) begin
      pend0 <= 1'b0;
    end
  end

  // Channel 1 requests: a rising request pin asks for one byte.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan1_request_in_q <= 1'b0;
      pend1 <= 1'b0;
      wbyte1 <= 8'h00;
    end else begin
      chan1_request_in_q <= chan1_request_in;
      if (!en[1]) begin
        pend1 <= 1'b0;
      end else if (ch1_evt) begin
        pend1 <= 1'b1;
        wbyte1 <= scsi_wdata;
      end else if (g1) begin
        pend1 <= 1'b0;
      end
    end
  end

  // RAM cycle issue, one byte per cycle at most.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ram_en <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= `BRAM_ADDR_RST;
      ram_wdata <= 8'h00;
      a_ch <= 1'b0;
      a_micro <= 1'b0;
    end else begin
      ram_en <= g0 | g1;
      ram_we <= g0 ? dir[0] : (g1 & dir[1]);
      ram_addr <= g0 ? addr[0] : addr[1];
      ram_wdata <= g0 ? wbyte0 : wbyte1;
      a_ch <= g1;
      a_micro <= g0 & src0_micro;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_valid <= 1'b0;
      b_ch <= 1'b0;
      b_micro <= 1'b0;
      b_rd <= 1'b0;
    end else begin
      b_valid <= ram_en;
      b_ch <= a_ch;
      b_micro <= a_micro;
      b_rd <= ~ram_we;
    end
  end

  // Byte returns and acknowledge pulses.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_ack <= 1'b0;
      seq_rdata <= 8'h00;
      ack1p <= 1'b0;
      scsi_rdata <= 8'h00;
    end else begin
      seq_ack <= b_valid & ~b_ch & ~b_micro;
      ack1p <= b_valid & b_ch;
      if (b_valid && !b_ch && !b_micro && b_rd) begin
        seq_rdata <= ram_rdata;
      end
      if (b_valid && b_ch && b_rd) begin
        scsi_rdata <= ram_rdata;
      end
    end
  end

  // In SCSI style the pin is a request, held until the host answers.
  assign chan1_acknowledge_out = (proto1 == BRAM_HS_SCSI) ?
    (en[1] & ~chan1_request_in & ~pend1 & ~busy1) : ack1p;

  a_dir0_cycle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    g0 |=> ram_en && ram_we == $past(dir[0]) && ram_addr == $past(addr[0])
  ) else $error("channel 0 cycle has wrong direction or address");

  a_dir1_cycle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    g1 |=> ram_en && ram_we == $past(dir[1]) && ram_addr == $past(addr[1])
  ) else $error("channel 1 cycle has wrong direction or address");

  a_irq_raise: assert property (
    @(posedge hclk) disable iff (!hresetn)
    |irq_evt |=> int_mem && (cause & $past(irq_evt)) == $past(irq_evt)
  ) else $error("block end did not raise the memory interrupt");

  a_irq_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    g0 && count[0] == 16'h0000 && cif[0].ctrl.keep_en && !cif[0].wr_ctrl
    |=> en[0] && !irq_evt[0]
  ) else $error("interrupt while channel stayed enabled");

  a_abort_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cif[0].wr_ctrl && !hwdata[0] |=> !en[0] ##1 !pend0 && !g0
  ) else $error("abort left a request pending");

  a_scsi_req: assert property (
    @(posedge hclk) disable iff (!hresetn)
    proto1 == BRAM_HS_SCSI && chan1_request_in |-> !chan1_acknowledge_out
  ) else $error("request held while host acknowledges");

  a_seq_return: assert property (
    @(posedge hclk) disable iff (!hresetn)
    g0 && !src0_micro |-> ##3 seq_ack
  ) else $error("sequencer byte not acknowledged in three cycles");
endmodule
`default_nettype wire

// ### bram_ram_model.sv
// Purpose: Byte-wide buffer RAM that stands beside the controller.
// Assumes: A read byte is due in the cycle after the enable pulse.
// Notes:   Outside a read the data lines toggle so stale bytes show.
`timescale 1ns/1ps
`default_nettype none
module bram_ram_model (
  // Clock
  input wire logic hclk,
  // RAM port
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:65535];

  initial begin
    ram_rdata = 8'h00;
  end

  always @(posedge hclk) begin
    if (ram_en && ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    if (ram_en && !ram_we) begin
      ram_rdata <= mem[ram_addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule
`default_nettype wire

// ### bram_dma_tb_top.sv
// Purpose: Self-checking bench for the buffer RAM controller.
// Assumes: Register byte address is four times the index.
// Notes:   Outputs are sampled at the falling edge, inputs move at rise.
`timescale 1ns/1ps
`default_nettype none
module bram_dma_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ram_en, ram_we, seq_req, seq_ack, int_mem, hresp;
  logic [15:0] ram_addr;
  logic [7:0] ram_wdata, ram_rdata, seq_wdata, seq_rdata;
  logic chan1_request_in, chan1_acknowledge_out;
  logic [7:0] scsi_wdata, scsi_rdata;
  int fail_count, n_checks;

  assign hready = hreadyout;

  bram_dma dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ram_en(ram_en), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .seq_req(seq_req),
    .seq_wdata(seq_wdata), .seq_ack(seq_ack), .seq_rdata(seq_rdata),
    .chan1_request_in(chan1_request_in), .scsi_wdata(scsi_wdata),
    .chan1_acknowledge_out(chan1_acknowledge_out),
    .scsi_rdata(scsi_rdata), .int_mem(int_mem)
  );

  bram_ram_model ram_u (
    .hclk(hclk), .ram_en(ram_en), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Waits until sig is high at a falling edge, then passes the next rise.
  task automatic await(ref logic sig);
    bit ok;
    ok = 1'b0;
    for (int k = 0; k < 40 && !ok; k++) begin
      @(negedge hclk);
      ok = sig;
      @(posedge hclk);
    end
    if (!ok) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic ahb(input bit wr, input logic [6:0] idx,
                     input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {23'h000000, idx, 2'h0};
    await(hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    await(hreadyout);
  endtask

  task automatic rchk(input logic [6:0] idx, input logic [7:0] exp);
    ahb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), hrdata, {24'h000000, exp});
  endtask

  task automatic seq_byte(input logic [7:0] d);
    seq_req <= 1'b1;
    seq_wdata <= d;
    @(posedge hclk);
    seq_req <= 1'b0;
    seq_wdata <= ~d;
    await(seq_ack);
  endtask

  task automatic scsi_byte(input bit p, input logic [7:0] d);
    if (p) begin
      await(chan1_acknowledge_out);
    end
    chan1_request_in <= 1'b1;
    scsi_wdata <= d;
    @(posedge hclk);
    chan1_request_in <= 1'b0;
    scsi_wdata <= ~d;
    if (p) begin
      repeat (6) @(posedge hclk);
    end else begin
      await(chan1_acknowledge_out);
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    seq_req = 1'b0;
    seq_wdata = 8'h00;
    chan1_request_in = 1'b0;
    scsi_wdata = 8'h00;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(7'h02, 8'h00);
    rchk(7'h07, 8'h00);
    rchk(7'h00, 8'h00);
    // Channel 0 into RAM across an address carry and a count borrow.
    ahb(1'b1, 7'h00, 8'hff);
    ahb(1'b1, 7'h01, 8'h12);
    ahb(1'b1, 7'h02, 8'h00);
    ahb(1'b1, 7'h03, 8'h01);
    ahb(1'b1, 7'h08, 8'h0b);
    seq_byte(8'haa);
    seq_byte(8'hbb);
    seq_byte(8'hcc);
    chk("ram 12ff", ram_u.mem[16'h12ff], 8'haa);
    chk("ram 1300", ram_u.mem[16'h1300], 8'hbb);
    chk("ram 1301", ram_u.mem[16'h1301], 8'hcc);
    rchk(7'h02, 8'hfd);
    rchk(7'h03, 8'h00);
    rchk(7'h00, 8'h04);
    // Abort with the interrupt enable kept, so the falling enable reports.
    ahb(1'b1, 7'h08, 8'h08);
    repeat (4) @(posedge hclk);
    chk("int_mem abort", int_mem, 1'b1);
    rchk(7'h00, 8'h01);
    repeat (3) @(posedge hclk);
    chk("int_mem cleared", int_mem, 1'b0);
    // Channel 0 out of RAM with reload and the channel kept enabled.
    ahb(1'b1, 7'h00, 8'hff);
    ahb(1'b1, 7'h01, 8'h12);
    ahb(1'b1, 7'h02, 8'h01);
    ahb(1'b1, 7'h03, 8'h00);
    ahb(1'b1, 7'h08, 8'h15);
    seq_byte(8'h00);
    chk("seq_rdata 0", seq_rdata, 8'haa);
    seq_byte(8'h00);
    chk("seq_rdata 1", seq_rdata, 8'hbb);
    rchk(7'h02, 8'h01);
    rchk(7'h03, 8'h00);
    seq_byte(8'h00);
    chk("seq_rdata 2", seq_rdata, 8'hcc);
    rchk(7'h00, 8'h04);
    ahb(1'b1, 7'h08, 8'h00);
    repeat (4) @(posedge hclk);
    chk("int_mem masked", int_mem, 1'b0);
    // Channel 1 into RAM, address wrapping past all ones.
    ahb(1'b1, 7'h04, 8'hff);
    ahb(1'b1, 7'h05, 8'hff);
    ahb(1'b1, 7'h06, 8'h01);
    ahb(1'b1, 7'h07, 8'h00);
    ahb(1'b1, 7'h09, 8'h0b);
    scsi_byte(1'b0, 8'h5a);
    scsi_byte(1'b0, 8'ha5);
    chk("ram ffff", ram_u.mem[16'hffff], 8'h5a);
    chk("ram 0000", ram_u.mem[16'h0000], 8'ha5);
    rchk(7'h06, 8'hff);
    rchk(7'h07, 8'hff);
    repeat (4) @(posedge hclk);
    chk("int_mem end", int_mem, 1'b1);
    rchk(7'h00, 8'h02);
    // Channel 1 out of RAM with the SCSI style handshake.
    ahb(1'b1, 7'h04, 8'hff);
    ahb(1'b1, 7'h05, 8'hff);
    ahb(1'b1, 7'h06, 8'h00);
    ahb(1'b1, 7'h07, 8'h00);
    ahb(1'b1, 7'h09, 8'h81);
    scsi_byte(1'b1, 8'h00);
    chk("scsi_rdata", scsi_rdata, 8'h5a);
    chk("ack level", chan1_acknowledge_out, 1'b0);
    rchk(7'h00, 8'h00);
    // Processor port into RAM, then back out of RAM.
    ahb(1'b1, 7'h00, 8'h00);
    ahb(1'b1, 7'h01, 8'h20);
    ahb(1'b1, 7'h02, 8'h01);
    ahb(1'b1, 7'h03, 8'h00);
    ahb(1'b1, 7'h08, 8'h03);
    ahb(1'b1, 7'h18, 8'h3c);
    ahb(1'b1, 7'h18, 8'hc3);
    ahb(1'b1, 7'h00, 8'h00);
    ahb(1'b1, 7'h01, 8'h20);
    chk("ram 2000", ram_u.mem[16'h2000], 8'h3c);
    chk("ram 2001", ram_u.mem[16'h2001], 8'hc3);
    ahb(1'b1, 7'h08, 8'h01);
    rchk(7'h18, 8'h3c);
    rchk(7'h18, 8'hc3);
    rchk(7'h30, 8'h00);
    chk("hresp", hresp, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
